// ### uart_async_receiver_baud.sv
// asynchronous serial receiver with baud rate generator and apb registers
//
// Local design decision: the APB slave port.
`timescale 1ns/1ns
`include "uart_rx_consts.svh"
module uart_async_receiver_baud #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial line
    input wire logic receive_data_pin,
    // timing and interrupt
    output logic sync_clock_tick,
    output logic irq
);
    import uart_rx_pkg::*;
    initial begin
        if (ADDR_W < 12) begin
            $error("ADDR_W must be at least 12");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers and decode
    uart_rx_pkg::reg8_t receive_status_control;
    uart_rx_pkg::reg8_t transmit_status_control;
    uart_rx_pkg::reg8_t baud_divisor;
    uart_rx_pkg::reg8_t peripheral_interrupt_flags;
    uart_rx_pkg::reg8_t peripheral_interrupt_enables;
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
        hit = (a == ADDR_W'({idx, 2'b00}));
    endfunction : hit
    logic wr_acc;
    logic rd_setup;
    logic rd_acc;
    logic mapped;
    logic wr_byte;
    assign wr_acc = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign wr_byte = wr_acc && pstrb[0] && mapped;
    always_comb begin
        if (hit(paddr, `IDX_RECEIVE_STATUS_CONTROL)) begin
            mapped = 1'b1;
        end else if (hit(paddr, `IDX_TRANSMIT_STATUS_CONTROL)) begin
            mapped = 1'b1;
        end else if (hit(paddr, `IDX_BAUD_DIVISOR)) begin
            mapped = 1'b1;
        end else if (hit(paddr, `IDX_RECEIVE_BUFFER)) begin
            mapped = 1'b1;
        end else if (hit(paddr, `IDX_INT_FLAGS)) begin
            mapped = 1'b1;
        end else if (hit(paddr, `IDX_INT_ENABLES)) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    logic rx_enabled;
    logic divisor_write;
    logic buffer_pop;
    assign divisor_write = wr_byte && hit(paddr, `IDX_BAUD_DIVISOR);
    assign buffer_pop = rd_acc && hit(paddr, `IDX_RECEIVE_BUFFER);
    assign rx_enabled = receive_status_control[`RCS_SERIAL_PORT_ENABLE]
        && receive_status_control[`RCS_CONT_RECEIVE]
        && !transmit_status_control[`TCS_SYNC_MODE];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            receive_status_control <= `RST_RECEIVE_STATUS_CONTROL;
            transmit_status_control <= `RST_TRANSMIT_STATUS_CONTROL;
            baud_divisor <= `RST_BAUD_DIVISOR;
            peripheral_interrupt_enables <= `RST_INT;
        end else if (wr_byte) begin
            if (hit(paddr, `IDX_RECEIVE_STATUS_CONTROL)) begin
                receive_status_control <= pwdata[7:0];
            end else if (hit(paddr, `IDX_TRANSMIT_STATUS_CONTROL)) begin
                transmit_status_control <= pwdata[7:0];
            end else if (hit(paddr, `IDX_BAUD_DIVISOR)) begin
                baud_divisor <= pwdata[7:0];
            end else if (hit(paddr, `IDX_INT_ENABLES)) begin
                peripheral_interrupt_enables <= pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // baud rate generator
    logic [7:0] baud_count;
    logic [1:0] prescale;
    logic divisor_wrap;
    logic sample_tick;
    assign divisor_wrap = (baud_count == baud_divisor);
    always_ff @(posedge sys_clk) begin
        if (rst || divisor_write) begin
            baud_count <= 8'h00;
            prescale <= 2'h0;
        end else if (divisor_wrap) begin
            baud_count <= 8'h00;
            prescale <= prescale + 2'h1;
        end else begin
            baud_count <= baud_count + 8'h01;
        end
    end
    // high speed: tick every divisor+1 clocks; otherwise every 4(divisor+1)
    assign sample_tick = divisor_wrap && (transmit_status_control[`TCS_HIGH_SPEED]
        || prescale == `LOW_SPEED_PRESCALE_LAST);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync_clock_tick <= 1'b0;
        end else begin
            sync_clock_tick <= transmit_status_control[`TCS_SYNC_MODE] && divisor_wrap
                && prescale == `LOW_SPEED_PRESCALE_LAST;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // line synchroniser and sample history
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic [2:0] history;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            pin_meta <= receive_data_pin;
            pin_sync <= pin_meta;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            history <= 3'b111;
            pin_prev <= 1'b1;
        end else if (sample_tick) begin
            history <= {history[1:0], pin_sync};
            pin_prev <= pin_sync;
        end
    end

    function automatic logic majority(input logic [2:0] s);
        majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : majority

    ////////////////////////////////////////////////////////////////////////
    // receive state machine
    rx_state_t state;
    logic [3:0] tick_count;
    logic [3:0] bit_count;
    logic [8:0] receive_shift_register;
    logic mid_bit;
    logic bit_value;
    logic stop_done;
    logic overrun_error;
    logic [1:0] fill;
    assign mid_bit = sample_tick && tick_count == `SAMPLE_LAST;
    assign bit_value = majority(history);
    assign stop_done = mid_bit && state == RX_STOP;

    always_ff @(posedge sys_clk) begin
        if (rst || !rx_enabled) begin
            state <= RX_IDLE;
            tick_count <= 4'h0;
            bit_count <= 4'h0;
            receive_shift_register <= 9'h000;
        end else if (sample_tick) begin
            tick_count <= tick_count + 4'h1;
            case (state)
                RX_IDLE: begin
                    tick_count <= 4'h1;
                    if (pin_prev && !pin_sync) begin
                        state <= RX_START;
                    end
                end
                RX_START: begin
                    if (tick_count == `SAMPLE_LAST) begin
                        if (bit_value) begin
                            state <= RX_IDLE;
                        end
                    end else if (tick_count == `TICKS_PER_BIT_LAST) begin
                        state <= RX_DATA;
                        bit_count <= 4'h0;
                    end
                end
                RX_DATA: begin
                    if (tick_count == `SAMPLE_LAST) begin
                        receive_shift_register[bit_count] <= bit_value;
                    end else if (tick_count == `TICKS_PER_BIT_LAST) begin
                        bit_count <= bit_count + 4'h1;
                        if (bit_count == `DATA_BITS_LAST + {3'h0, receive_status_control[`RCS_NINE_BIT_RECEIVE]}) begin
                            state <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (tick_count == `SAMPLE_LAST) begin
                        state <= RX_IDLE;
                    end
                end
                default: begin
                    state <= RX_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two-entry receive buffer with framing and ninth bit
    logic [9:0] receive_buffer [2];
    logic wr_ptr;
    logic rd_ptr;
    logic push;
    logic pop;
    logic framing_now;
    assign framing_now = !bit_value;
    assign push = stop_done && !overrun_error && fill != 2'h2;
    assign pop = buffer_pop && fill != 2'h0;
    always_ff @(posedge sys_clk) begin
        if (push) begin
            receive_buffer[wr_ptr] <= {framing_now,
                receive_shift_register[8] & receive_status_control[`RCS_NINE_BIT_RECEIVE],
                receive_shift_register[7:0]};
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            fill <= 2'h0;
        end else begin
            wr_ptr <= wr_ptr ^ push;
            rd_ptr <= rd_ptr ^ pop;
            fill <= fill + {1'b0, push} - {1'b0, pop};
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst || !receive_status_control[`RCS_CONT_RECEIVE]) begin
            overrun_error <= 1'b0;
        end else if (stop_done && fill == 2'h2) begin
            overrun_error <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt flags
    logic receive_ready_flag;
    logic [9:0] head;
    logic [1:0] sticky;
    assign receive_ready_flag = fill != 2'h0;
    assign head = receive_buffer[rd_ptr];
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sticky <= 2'b00;
        end else begin
            // new events win over a clear in the same cycle
            sticky[0] <= (stop_done && fill == 2'h2 && !overrun_error)
                || (sticky[0] && !(wr_byte && hit(paddr, `IDX_INT_FLAGS) && pwdata[`INT_OVERRUN_EVENT]));
            sticky[1] <= (push && framing_now)
                || (sticky[1] && !(wr_byte && hit(paddr, `IDX_INT_FLAGS) && pwdata[`INT_FRAMING_EVENT]));
        end
    end
    always_comb begin
        peripheral_interrupt_flags = 8'h00;
        peripheral_interrupt_flags[`INT_RECEIVE_READY] = receive_ready_flag;
        peripheral_interrupt_flags[`INT_OVERRUN_EVENT] = sticky[0];
        peripheral_interrupt_flags[`INT_FRAMING_EVENT] = sticky[1];
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(peripheral_interrupt_flags & peripheral_interrupt_enables);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, captured in the setup phase
    uart_rx_pkg::reg8_t status_view;
    always_comb begin
        status_view = receive_status_control;
        status_view[`RCS_FRAMING_ERROR] = receive_ready_flag & head[9];
        status_view[`RCS_OVERRUN_ERROR] = overrun_error;
        status_view[`RCS_NINTH_BIT] = receive_ready_flag & head[8];
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            if (hit(paddr, `IDX_RECEIVE_STATUS_CONTROL)) begin
                prdata <= {24'h00_0000, status_view};
            end else if (hit(paddr, `IDX_TRANSMIT_STATUS_CONTROL)) begin
                prdata <= {24'h00_0000, transmit_status_control | (8'h01 << `TCS_SHIFT_EMPTY)};
            end else if (hit(paddr, `IDX_BAUD_DIVISOR)) begin
                prdata <= {24'h00_0000, baud_divisor};
            end else if (hit(paddr, `IDX_RECEIVE_BUFFER)) begin
                prdata <= {24'h00_0000, receive_ready_flag ? head[7:0] : 8'h00};
            end else if (hit(paddr, `IDX_INT_FLAGS)) begin
                prdata <= {24'h00_0000, peripheral_interrupt_flags};
            end else if (hit(paddr, `IDX_INT_ENABLES)) begin
                prdata <= {24'h00_0000, peripheral_interrupt_enables};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end
endmodule : uart_async_receiver_baud

// ### uart_rx_consts.svh
// register map, field positions and reset values of the serial receiver
`ifndef UART_RX_CONSTS_SVH
`define UART_RX_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_RECEIVE_STATUS_CONTROL 10'h018
`define IDX_TRANSMIT_STATUS_CONTROL 10'h098
`define IDX_BAUD_DIVISOR 10'h099
`define IDX_RECEIVE_BUFFER 10'h01A
`define IDX_INT_FLAGS 10'h00C
`define IDX_INT_ENABLES 10'h08C

// receive status and control fields
`define RCS_SERIAL_PORT_ENABLE 7
`define RCS_NINE_BIT_RECEIVE 6
`define RCS_SINGLE_RECEIVE 5
`define RCS_CONT_RECEIVE 4
`define RCS_ADDRESS_DETECT 3
`define RCS_FRAMING_ERROR 2
`define RCS_OVERRUN_ERROR 1
`define RCS_NINTH_BIT 0

// transmit status and control fields
`define TCS_SYNC_MODE 4
`define TCS_HIGH_SPEED 2
`define TCS_SHIFT_EMPTY 1

// interrupt flag and enable fields
`define INT_RECEIVE_READY 5
`define INT_FRAMING_EVENT 2
`define INT_OVERRUN_EVENT 1
`define INT_EVENT_MASK 8'h06

// reset values
`define RST_RECEIVE_STATUS_CONTROL 8'h00
`define RST_TRANSMIT_STATUS_CONTROL 8'h02
`define RST_BAUD_DIVISOR 8'h00
`define RST_INT 8'h00

// bit timing, in ticks of the sixteen-times sample clock
`define SAMPLE_LAST 4'h9
`define TICKS_PER_BIT_LAST 4'hF
`define DATA_BITS_LAST 4'h7
`define LOW_SPEED_PRESCALE_LAST 2'h3

`endif

// ### uart_rx_pkg.sv
// types shared by the serial receiver
package uart_rx_pkg;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b11,
        RX_STOP = 2'b10
    } rx_state_t;
    typedef logic [7:0] reg8_t;
endpackage : uart_rx_pkg

// ### uart_rx_checker.sv
// assertion checker on the serial receiver ports
`timescale 1ns/1ns
module uart_rx_checker #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic receive_data_pin,
    input wire logic sync_clock_tick,
    input wire logic irq
);
    logic wr;
    logic wdiv;
    logic sync;
    logic by_tick;
    logic by_wr;
    logic [7:0] div;
    logic [7:0] ena;
    logic [10:0] cnt;
    logic [10:0] per;
    assign wr = psel && penable && pwrite && pstrb[0];
    assign wdiv = wr && paddr == 12'h264;
    assign per = {1'b0, div, 2'b00} + 11'h004;
    ////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div <= 8'h00;
            sync <= 1'b0;
            ena <= 8'h00;
        end else if (wr) begin
            div <= wdiv ? pwdata[7:0] : div;
            sync <= (paddr == 12'h260) ? pwdata[4] : sync;
            ena <= (paddr == 12'h230) ? pwdata[7:0] : ena;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst || (wr && paddr == 12'h260)) begin
            cnt <= 11'h000;
            by_tick <= 1'b0;
            by_wr <= 1'b0;
        end else if (sync_clock_tick || wdiv) begin
            cnt <= 11'h001;
            by_tick <= !wdiv;
            by_wr <= wdiv;
        end else if (cnt != 11'h7FF) begin
            cnt <= cnt + 11'h001;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_tick_period: assert property (sync_clock_tick && by_tick |-> cnt == per)
        else $error("sync tick period wrong");
    a_tick_overdue: assert property (sync && by_tick |-> cnt <= per)
        else $error("sync tick missing");
    a_tick_restart: assert property (sync && by_wr |-> cnt <= per + 11'h001 &&
        (!sync_clock_tick || cnt + 11'h001 >= per))
        else $error("divisor write did not restart timer");
    a_tick_sync_only: assert property (!sync && !$past(sync) && !$past(sync, 2) |-> !sync_clock_tick)
        else $error("tick outside sync mode");
    a_irq_cause: assert property (irq |-> ($past(ena) & 8'h26) != 8'h00)
        else $error("irq without enable");
    a_ready_high: assert property (psel && penable |-> pready)
        else $error("pready low");
    a_slverr_map: assert property (pslverr == (psel && penable &&
        !(paddr inside {12'h060, 12'h260, 12'h264, 12'h068, 12'h030, 12'h230})))
        else $error("pslverr wrong");
    a_rdata_upper: assert property (prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    c_tick_pair: cover property (sync_clock_tick && by_tick);
    c_irq: cover property (irq);
    c_slverr: cover property (pslverr);
endmodule : uart_rx_checker

bind uart_async_receiver_baud uart_rx_checker #(.ADDR_W(ADDR_W)) u_uart_rx_checker (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .receive_data_pin(receive_data_pin), .sync_clock_tick(sync_clock_tick), .irq(irq));

// ### uart_line_driver.sv
// serial transmitter model driving the receive pin
`timescale 1ns/1ns
module uart_line_driver (
    // clock
    input wire logic sys_clk,
    // serial line, idle high
    output logic line
);
    initial line = 1'b1;
    task automatic hold(input logic v, input int clks);
        line <= v;
        repeat (clks) @(posedge sys_clk);
    endtask : hold
    task automatic send(input logic [8:0] d, input logic nine, input logic stop_ok, input int bclk);
        hold(1'b0, bclk);
        for (int i = 0; i < 8 + nine; i++) begin
            hold(d[i], bclk);
        end
        hold(stop_ok, bclk);
        hold(1'b1, bclk);
    endtask : send
endmodule : uart_line_driver

// ### test_uart_async_receiver_baud.sv
// self-checking bench for the serial receiver
`timescale 1ns/1ns
`include "uart_rx_consts.svh"
module test_uart_async_receiver_baud;
    import uart_rx_pkg::*;
    typedef struct packed {
        reg8_t div;
        logic hs;
        logic nine;
        logic stop_ok;
        logic [8:0] d;
        reg8_t st;
    } row_t;
    localparam logic [11:0] A_RSC = {`IDX_RECEIVE_STATUS_CONTROL, 2'b00};
    localparam logic [11:0] A_TSC = {`IDX_TRANSMIT_STATUS_CONTROL, 2'b00};
    localparam logic [11:0] A_DIV = {`IDX_BAUD_DIVISOR, 2'b00};
    localparam logic [11:0] A_BUF = {`IDX_RECEIVE_BUFFER, 2'b00};
    localparam logic [11:0] A_FLG = {`IDX_INT_FLAGS, 2'b00};
    localparam logic [11:0] A_ENA = {`IDX_INT_ENABLES, 2'b00};
    localparam int B = 16;
    row_t rows [5] = '{
        '{8'h00, 1'b1, 1'b0, 1'b1, 9'h0A5, 8'h90},
        '{8'h00, 1'b0, 1'b0, 1'b1, 9'h03C, 8'h90},
        '{8'h01, 1'b1, 1'b1, 1'b1, 9'h181, 8'hD1},
        '{8'h02, 1'b0, 1'b1, 1'b1, 9'h0C3, 8'hD0},
        '{8'h00, 1'b1, 1'b0, 1'b0, 9'h05A, 8'h94}};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic line;
    logic sync_clock_tick;
    logic irq;
    logic [31:0] rd;
    int errors = 0;
    int check_count = 0;
    int n;
    always #25 sys_clk = ~sys_clk;
    uart_async_receiver_baud u_uart_async_receiver_baud (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .receive_data_pin(line), .sync_clock_tick(sync_clock_tick), .irq(irq));
    uart_line_driver u_uart_line_driver (.sys_clk(sys_clk), .line(line));
    ////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input reg8_t d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errors++;
            end_sim();
        end
        @(posedge sys_clk);
    endtask : apb
    task automatic rchk(input logic [11:0] a, input reg8_t exp);
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h000000, exp});
    endtask : rchk
    task automatic wait_rx;
        n = 0;
        do begin
            apb(1'b0, A_FLG, 8'h00);
            n++;
        end while (rd[`INT_RECEIVE_READY] !== 1'b1 && n < 40);
        if (rd[`INT_RECEIVE_READY] !== 1'b1) begin
            errors++;
            end_sim();
        end
    endtask : wait_rx
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rchk(A_RSC, 8'h00);
        rchk(A_TSC, 8'h02);
        rchk(A_DIV, 8'h00);
        rchk(A_ENA, 8'h00);
        foreach (rows[i]) begin
            apb(1'b1, A_DIV, rows[i].div);
            apb(1'b1, A_TSC, {5'h00, rows[i].hs, 2'b00});
            apb(1'b1, A_RSC, {1'b1, rows[i].nine, 6'h10});
            u_uart_line_driver.send(rows[i].d, rows[i].nine, rows[i].stop_ok,
                16 * (rows[i].div + 1) * (rows[i].hs ? 1 : 4));
            wait_rx();
            rchk(A_RSC, rows[i].st);
            rchk(A_BUF, rows[i].d[7:0]);
            rchk(A_FLG, {5'h00, !rows[i].stop_ok, 2'b00});
        end
        apb(1'b1, A_FLG, 8'h04);
        rchk(A_FLG, 8'h00);
        u_uart_line_driver.send(9'h011, 1'b0, 1'b0, B);
        u_uart_line_driver.send(9'h022, 1'b0, 1'b1, B);
        u_uart_line_driver.send(9'h033, 1'b0, 1'b1, B);
        rchk(A_RSC, 8'h96);
        rchk(A_BUF, 8'h11);
        u_uart_line_driver.send(9'h044, 1'b0, 1'b1, B);
        rchk(A_RSC, 8'h92);
        rchk(A_BUF, 8'h22);
        rchk(A_BUF, 8'h00);
        rchk(A_FLG, 8'h06);
        apb(1'b1, A_FLG, 8'h26);
        rchk(A_FLG, 8'h00);
        apb(1'b1, A_RSC, 8'h80);
        u_uart_line_driver.send(9'h077, 1'b0, 1'b1, B);
        rchk(A_FLG, 8'h00);
        apb(1'b1, A_RSC, 8'h10);
        u_uart_line_driver.send(9'h066, 1'b0, 1'b1, B);
        rchk(A_FLG, 8'h00);
        apb(1'b1, A_RSC, 8'h90);
        rchk(A_RSC, 8'h90);
        u_uart_line_driver.hold(1'b0, 3);
        u_uart_line_driver.hold(1'b1, 4 * B);
        rchk(A_FLG, 8'h00);
        apb(1'b1, A_ENA, 8'h20);
        u_uart_line_driver.hold(1'b0, 7);
        u_uart_line_driver.hold(1'b1, 1);
        u_uart_line_driver.hold(1'b0, B - 8);
        for (int i = 0; i < 8; i++) begin
            u_uart_line_driver.hold(!i[0], B);
        end
        u_uart_line_driver.hold(1'b1, 2 * B);
        wait_rx();
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, A_ENA, 8'h00);
        @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, A_ENA, 8'h20);
        rchk(A_BUF, 8'h55);
        @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        pstrb <= 4'h0;
        apb(1'b1, A_DIV, 8'h55);
        pstrb <= 4'hF;
        apb(1'b1, 12'h100, 8'h55);
        rchk(A_DIV, 8'h00);
        rchk(12'h100, 8'h00);
        apb(1'b1, A_DIV, 8'h02);
        apb(1'b1, A_TSC, 8'h10);
        repeat (20) @(posedge sys_clk);
        n = 0;
        repeat (120) begin
            @(posedge sys_clk);
            n += (sync_clock_tick === 1'b1);
        end
        chk(n, 10);
        apb(1'b1, A_DIV, 8'h00);
        repeat (30) @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rchk(A_TSC, 8'h02);
        end_sim();
    end
endmodule : test_uart_async_receiver_baud
